// file: rtl/hsp_defs.svh
// Constants shared by both ends of the host serial port
`ifndef HSP_DEFS_SVH
`define HSP_DEFS_SVH

`define HSP_CLK_HZ       100000000
`define HSP_BAUD         115200
`define HSP_BIT_CYC      (`HSP_CLK_HZ / `HSP_BAUD)
`define HSP_SPI_MAX_BPS  6000000
// Half period rounded up so the master never exceeds the limit
`define HSP_SPI_HALF     ((`HSP_CLK_HZ + 2 * `HSP_SPI_MAX_BPS - 1) / (2 * `HSP_SPI_MAX_BPS))
`define HSP_IDLE_BYTE    8'h00

`define HSP_A_CTRL       8'h00
`define HSP_A_STATUS     8'h04
`define HSP_A_MASK       8'h08
`define HSP_A_UTX        8'h0c
`define HSP_A_URX        8'h10
`define HSP_A_STX        8'h14
`define HSP_A_SRX        8'h18
`define HSP_A_LINK       8'h1c

`define HSP_CTRL_PULL    0
`define HSP_CTRL_RST     1'b1
`define HSP_ST_URX       0
`define HSP_ST_UERR      1
`define HSP_ST_SRX       2
`define HSP_ST_STX       3

`endif

// file: rtl/hsp_pkg.sv
// Types of the host serial port
package hsp_pkg;

	typedef enum logic [2:0] {
		HSP_U_IDLE  = 3'b001,
		HSP_U_START = 3'b010,
		HSP_U_DATA  = 3'b100
	} hsp_urx_st_t;

	typedef enum logic [4:0] {
		HSP_H_IDLE = 5'b00001,
		HSP_H_SEL  = 5'b00010,
		HSP_H_HI   = 5'b00100,
		HSP_H_LO   = 5'b01000,
		HSP_H_END  = 5'b10000
	} hsp_hst_t;

	typedef struct packed {
		logic [15:0] tcnt;
		logic [3:0]  tbit;
		logic [9:0]  tsh;
		logic [1:0]  rsy;
		hsp_urx_st_t rst;
		logic [15:0] rcnt;
		logic [3:0]  rbit;
		logic [7:0]  rsh;
		logic [7:0]  rdat;
		logic        rvld;
		logic        rerr;
	} hsp_uart_t;

	typedef struct packed {
		logic [2:0] sclk_s;
		logic [2:0] ssel_s;
		logic [1:0] mosi_s;
		logic [7:0] tx_sh;
		logic [7:0] rx_sh;
		logic [2:0] bcnt;
		logic [7:0] q_dat;
		logic       q_vld;
		logic       tx_act;
		logic [7:0] srx;
		logic [7:0] urx;
		logic       pull_en;
		logic [3:0] sts;
		logic [3:0] msk;
	} hsp_dev_t;

	typedef struct packed {
		hsp_hst_t   st;
		logic [7:0] cnt;
		logic [3:0] bits;
		logic [7:0] sh;
		logic [7:0] rsh;
		logic [7:0] rdat;
		logic       done;
		logic       sclk;
		logic       ssel_n;
		logic [1:0] miso_s;
		logic [1:0] attn_s;
	} hsp_host_t;

endpackage : hsp_pkg

// file: rtl/hsp_if.sv
// Pins between the radio module end and the host controller end
`timescale 1ns/1ps
`default_nettype none
interface hsp_if;
	logic u_d2h;
	logic u_h2d;
	logic sclk;
	logic ssel_n;
	logic mosi;
	logic miso_o;
	logic miso_oe;
	logic miso;
	logic attn_n;

	// Released line floats high through the pull-up
	assign miso = miso_oe ? miso_o : 1'b1;

	modport dev (input u_h2d, sclk, ssel_n, mosi, output u_d2h, miso_o, miso_oe, attn_n);
	modport host (input u_d2h, miso, attn_n, output u_h2d, sclk, ssel_n, mosi);
endinterface : hsp_if
`default_nettype wire

// file: rtl/hsp_uart.sv
// Eight data bits, no parity, one stop bit UART used by both ends
`timescale 1ns/1ps
`default_nettype none
`include "hsp_defs.svh"
module hsp_uart import hsp_pkg::*; (
	input  wire logic       mclk,     // System clock
	input  wire logic       srst,     // Synchronous reset
	input  wire logic [7:0] tx_data,  // Byte to send
	input  wire logic       tx_valid, // Send request
	output logic            tx_ready, // Transmitter idle
	output logic [7:0]      rx_data,  // Last received byte
	output logic            rx_valid, // Good byte pulse
	output logic            rx_err,   // Bad stop bit pulse
	output logic            txd,      // Serial out
	input  wire logic       rxd       // Serial in, asynchronous
);
	localparam logic [15:0] BIT_M1  = 16'(`HSP_BIT_CYC - 1);
	localparam logic [15:0] HALF_M1 = 16'(`HSP_BIT_CYC / 2 - 1);

	hsp_uart_t r_reg, r_next;

	always_comb begin
		r_next = r_reg;
		r_next.rvld = 1'b0;
		r_next.rerr = 1'b0;
		r_next.rsy = {r_reg.rsy[0], rxd};
		if (r_reg.tbit != 4'h0) begin
			if (r_reg.tcnt == 16'h0000) begin
				r_next.tcnt = BIT_M1;
				r_next.tbit = r_reg.tbit - 4'h1;
				r_next.tsh  = {1'b1, r_reg.tsh[9:1]};
			end else begin
				r_next.tcnt = r_reg.tcnt - 16'h0001;
			end
		end else if (tx_valid) begin
			r_next.tsh  = {1'b1, tx_data, 1'b0};
			r_next.tbit = 4'ha;
			r_next.tcnt = BIT_M1;
		end
		unique case (r_reg.rst)
			HSP_U_IDLE: begin
				if (!r_reg.rsy[1]) begin
					r_next.rst  = HSP_U_START;
					r_next.rcnt = HALF_M1;
				end
			end
			HSP_U_START: begin
				if (r_reg.rcnt != 16'h0000) begin
					r_next.rcnt = r_reg.rcnt - 16'h0001;
				end else if (r_reg.rsy[1]) begin
					// Too short for a start bit
					r_next.rst = HSP_U_IDLE;
				end else begin
					r_next.rst  = HSP_U_DATA;
					r_next.rcnt = BIT_M1;
					r_next.rbit = 4'h0;
				end
			end
			HSP_U_DATA: begin
				if (r_reg.rcnt != 16'h0000) begin
					r_next.rcnt = r_reg.rcnt - 16'h0001;
				end else if (r_reg.rbit == 4'h8) begin
					r_next.rst  = HSP_U_IDLE;
					r_next.rdat = r_reg.rsh;
					r_next.rvld = r_reg.rsy[1];
					r_next.rerr = !r_reg.rsy[1];
				end else begin
					r_next.rcnt = BIT_M1;
					r_next.rsh  = {r_reg.rsy[1], r_reg.rsh[7:1]};
					r_next.rbit = r_reg.rbit + 4'h1;
				end
			end
			default: r_next.rst = HSP_U_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			r_reg <= '{tcnt: 16'h0000, tbit: 4'h0, tsh: 10'h3ff, rsy: 2'h3, rst: HSP_U_IDLE,
				rcnt: 16'h0000, rbit: 4'h0, rsh: 8'h00, rdat: 8'h00, rvld: 1'b0, rerr: 1'b0};
		end else begin
			r_reg <= r_next;
		end
	end

	assign tx_ready = (r_reg.tbit == 4'h0);
	assign txd      = r_reg.tsh[0];
	assign rx_data  = r_reg.rdat;
	assign rx_valid = r_reg.rvld;
	assign rx_err   = r_reg.rerr;
endmodule : hsp_uart
`default_nettype wire

// file: rtl/hsp_dev.sv
// Radio module end: UART, mode 0 SPI slave, APB registers and interrupt
// Function
// - idle UART line held high
// - start, eight bits LSB first, stop
// - both UARTs share one framing setup
// - SPI port is slave only
// - selected, shift one MISO bit per clock
// - deselected, MISO released
// - master selects and sets MOSI in one cycle, half a period before the first clock edge
// - master clock at most 6 Mb/s
// - select low means selected
// - attention low until queue clocked out
// - attention always actively driven
// - mode 0, MSB first
// - SPI carries unescaped API frames
// - pull-ups on after reset, software disables
`timescale 1ns/1ps
`default_nettype none
`include "hsp_defs.svh"
module hsp_dev import hsp_pkg::*; (
	input  wire logic        mclk,       // System clock
	input  wire logic        srst,       // Synchronous reset
	input  wire logic        psel,       // APB select
	input  wire logic        penable,    // APB access phase
	input  wire logic        pwrite,     // APB write
	input  wire logic [7:0]  paddr,      // APB byte address
	input  wire logic [31:0] pwdata,     // APB write data
	output logic [31:0]      prdata,     // APB read data
	output logic             pready,     // APB ready
	output logic             pslverr,    // APB error
	output logic             irq,        // Level interrupt
	output logic             pullup_en,  // Input pull-up control
	hsp_if.dev               link        // Pins to the host
);
	hsp_dev_t r_reg, r_next;

	logic       acc;
	logic       wr;
	logic       rd;
	logic       sel;
	logic       sel_fall;
	logic       sel_rise;
	logic       sck_rise;
	logic       sck_fall;
	logic       utx_ready;
	logic [7:0] urx_data;
	logic       urx_valid;
	logic       urx_err;
	logic       abort;
	logic [3:0] set;

	function automatic logic hsp_known(input logic [7:0] a);
		hsp_known = (a[1:0] == 2'b00) && (a <= `HSP_A_LINK);
	endfunction : hsp_known

	assign acc = psel && penable;
	assign wr  = acc && pwrite && hsp_known(paddr);
	assign rd  = acc && !pwrite && hsp_known(paddr);

	assign sel      = !r_reg.ssel_s[1];
	assign sel_fall = !r_reg.ssel_s[1] && r_reg.ssel_s[2];
	assign sel_rise = r_reg.ssel_s[1] && !r_reg.ssel_s[2];
	assign sck_rise = sel && r_reg.sclk_s[1] && !r_reg.sclk_s[2];
	assign sck_fall = sel && !r_reg.sclk_s[1] && r_reg.sclk_s[2];
	// Byte cut short by deselect goes back to the queue
	assign abort    = sel_rise && r_reg.tx_act;

	////////////////////////////////////////////////////////////////////
	// UART framing
	hsp_uart u_uart (
		.mclk     (mclk),
		.srst     (srst),
		.tx_data  (pwdata[7:0]),
		.tx_valid (wr && (paddr == `HSP_A_UTX)),
		.tx_ready (utx_ready),
		.rx_data  (urx_data),
		.rx_valid (urx_valid),
		.rx_err   (urx_err),
		.txd      (link.u_d2h),
		.rxd      (link.u_h2d)
	);

	////////////////////////////////////////////////////////////////////
	always_comb begin
		r_next = r_reg;
		set    = 4'h0;
		// clock and data come from the master
		r_next.sclk_s = {r_reg.sclk_s[1:0], link.sclk};
		r_next.ssel_s = {r_reg.ssel_s[1:0], link.ssel_n};
		r_next.mosi_s = {r_reg.mosi_s[0], link.mosi};

		// first bit ready at select fall
		if (sel_fall) begin
			r_next.tx_sh  = r_reg.q_vld ? r_reg.q_dat : `HSP_IDLE_BYTE;
			r_next.tx_act = r_reg.q_vld;
			r_next.q_vld  = 1'b0;
			r_next.bcnt   = 3'h0;
		end else if (!sel) begin
			r_next.bcnt   = 3'h0;
			r_next.tx_act = 1'b0;
			if (abort) begin
				r_next.q_vld = 1'b1;
			end
		end else if (sck_rise) begin
			// sample on rising edge, MSB first
			r_next.rx_sh = {r_reg.rx_sh[6:0], r_reg.mosi_s[1]};
			r_next.bcnt  = r_reg.bcnt + 3'h1;
			if (r_reg.bcnt == 3'h7) begin
				r_next.srx       = {r_reg.rx_sh[6:0], r_reg.mosi_s[1]};
				set[`HSP_ST_SRX] = 1'b1;
				if (r_reg.tx_act) begin
					set[`HSP_ST_STX] = 1'b1;
					r_next.tx_act    = 1'b0;
				end
			end
		end else if (sck_fall) begin
			if (r_reg.bcnt == 3'h0) begin
				r_next.tx_sh  = r_reg.q_vld ? r_reg.q_dat : `HSP_IDLE_BYTE;
				r_next.tx_act = r_reg.q_vld;
				r_next.q_vld  = 1'b0;
			end else begin
				r_next.tx_sh = {r_reg.tx_sh[6:0], 1'b0};
			end
		end

		if (urx_valid) begin
			r_next.urx       = urx_data;
			set[`HSP_ST_URX] = 1'b1;
		end
		set[`HSP_ST_UERR] = urx_err;

		if (wr) begin
			unique case (paddr)
				`HSP_A_CTRL: begin
					r_next.pull_en = pwdata[`HSP_CTRL_PULL];
				end
				`HSP_A_MASK: r_next.msk = pwdata[3:0];
				`HSP_A_STX: begin
					// Refused while a byte waits
					if (!r_reg.q_vld && !abort) begin
						r_next.q_dat = pwdata[7:0];
						r_next.q_vld = 1'b1;
					end
				end
				default: ;
			endcase
		end

		// New event beats the read that clears
		if (rd && (paddr == `HSP_A_STATUS)) begin
			r_next.sts = set;
		end else begin
			r_next.sts = r_reg.sts | set;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			r_reg <= '{sclk_s: 3'h0, ssel_s: 3'h7, mosi_s: 2'h0, tx_sh: 8'h00, rx_sh: 8'h00,
				bcnt: 3'h0, q_dat: 8'h00, q_vld: 1'b0, tx_act: 1'b0, srx: 8'h00, urx: 8'h00,
				pull_en: `HSP_CTRL_RST, sts: 4'h0, msk: 4'h0};
		end else begin
			r_reg <= r_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	always_comb begin
		prdata = 32'h0000_0000;
		if (rd) begin
			unique case (paddr)
				`HSP_A_CTRL:   prdata = {31'h0, r_reg.pull_en};
				`HSP_A_STATUS: prdata = {28'h0, r_reg.sts};
				`HSP_A_MASK:   prdata = {28'h0, r_reg.msk};
				`HSP_A_UTX:    prdata = {31'h0, !utx_ready};
				`HSP_A_URX:    prdata = {24'h0, r_reg.urx};
				`HSP_A_STX:    prdata = {30'h0, r_reg.tx_act, r_reg.q_vld};
				`HSP_A_SRX:    prdata = {24'h0, r_reg.srx};
				`HSP_A_LINK:   prdata = {30'h0, !link.attn_n, sel};
				default:       prdata = 32'h0000_0000;
			endcase
		end
	end

	assign pready    = 1'b1;
	assign pslverr   = acc && !hsp_known(paddr);
	assign irq       = |(r_reg.sts & r_reg.msk);
	assign pullup_en = r_reg.pull_en;

	assign link.miso_o  = r_reg.tx_sh[7];
	assign link.miso_oe = sel;
	assign link.attn_n  = !(r_reg.q_vld || r_reg.tx_act);
endmodule : hsp_dev
`default_nettype wire

// file: rtl/hsp_host.sv
// Host controller end: UART peer and mode 0 SPI master
`timescale 1ns/1ps
`default_nettype none
`include "hsp_defs.svh"
module hsp_host import hsp_pkg::*; (
	input  wire logic       mclk,       // System clock
	input  wire logic       srst,       // Synchronous reset
	input  wire logic [7:0] utx_data,   // UART byte to send
	input  wire logic       utx_valid,  // UART send request
	output logic            utx_ready,  // UART idle
	output logic [7:0]      urx_data,   // UART byte received
	output logic            urx_valid,  // UART byte pulse
	output logic            urx_err,    // UART stop bit error pulse
	input  wire logic [7:0] spi_wdata,  // SPI byte to send
	input  wire logic       spi_valid,  // SPI transfer request
	output logic            spi_ready,  // SPI master idle
	output logic [7:0]      spi_rdata,  // SPI byte received
	output logic            spi_done,   // SPI transfer done pulse
	output logic            attn_seen,  // Device has data queued
	hsp_if.host             link        // Pins to the device
);
	localparam logic [7:0] HALF_M1 = 8'(`HSP_SPI_HALF - 1);

	hsp_host_t r_reg, r_next;

	// same framing on the host side
	hsp_uart u_uart (
		.mclk     (mclk),
		.srst     (srst),
		.tx_data  (utx_data),
		.tx_valid (utx_valid),
		.tx_ready (utx_ready),
		.rx_data  (urx_data),
		.rx_valid (urx_valid),
		.rx_err   (urx_err),
		.txd      (link.u_h2d),
		.rxd      (link.u_d2h)
	);

	////////////////////////////////////////////////////////////////////
	always_comb begin
		r_next = r_reg;
		r_next.done   = 1'b0;
		r_next.miso_s = {r_reg.miso_s[0], link.miso};
		r_next.attn_s = {r_reg.attn_s[0], link.attn_n};
		if (r_reg.cnt != 8'h00) begin
			r_next.cnt = r_reg.cnt - 8'h01;
		end else begin
			unique case (r_reg.st)
				HSP_H_IDLE: begin
					if (spi_valid) begin
						r_next.sh     = spi_wdata;
						r_next.ssel_n = 1'b0;
						r_next.bits   = 4'h0;
						r_next.cnt    = HALF_M1;
						r_next.st     = HSP_H_SEL;
					end
				end
				HSP_H_SEL, HSP_H_LO: begin
					r_next.sclk = 1'b1;
					r_next.rsh  = {r_reg.rsh[6:0], r_reg.miso_s[1]};
					r_next.bits = r_reg.bits + 4'h1;
					r_next.cnt  = HALF_M1;
					r_next.st   = HSP_H_HI;
				end
				HSP_H_HI: begin
					r_next.sclk = 1'b0;
					r_next.cnt  = HALF_M1;
					if (r_reg.bits == 4'h8) begin
						r_next.st = HSP_H_END;
					end else begin
						r_next.sh = {r_reg.sh[6:0], 1'b0};
						r_next.st = HSP_H_LO;
					end
				end
				HSP_H_END: begin
					// Deselect, then hold high one half period
					r_next.cnt = HALF_M1;
					if (r_reg.bits == 4'h8) begin
						r_next.ssel_n = 1'b1;
						r_next.bits   = 4'h9;
					end else begin
						r_next.rdat = r_reg.rsh;
						r_next.done = 1'b1;
						r_next.cnt  = 8'h00;
						r_next.st   = HSP_H_IDLE;
					end
				end
				default: r_next.st = HSP_H_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			r_reg <= '{st: HSP_H_IDLE, cnt: 8'h00, bits: 4'h0, sh: 8'h00, rsh: 8'h00,
				rdat: 8'h00, done: 1'b0, sclk: 1'b0, ssel_n: 1'b1, miso_s: 2'h3,
				attn_s: 2'h3};
		end else begin
			r_reg <= r_next;
		end
	end

	assign spi_ready   = (r_reg.st == HSP_H_IDLE) && (r_reg.cnt == 8'h00);
	assign spi_rdata   = r_reg.rdat;
	assign spi_done    = r_reg.done;
	assign attn_seen   = !r_reg.attn_s[1];
	// half period rounded up keeps rate legal
	assign link.sclk   = r_reg.sclk;
	assign link.ssel_n = r_reg.ssel_n;
	assign link.mosi   = r_reg.sh[7];
endmodule : hsp_host
`default_nettype wire

// file: tb/hsp_link_assertions.sv
// Pin-level checks between the two ends of the host serial port
`timescale 1ns/1ps
`default_nettype none
`include "hsp_defs.svh"
module hsp_link_assertions (
	input wire logic mclk,    // Clock
	input wire logic srst,    // Reset
	input wire logic u_d2h,   // UART to host
	input wire logic u_h2d,   // UART to device
	input wire logic sclk,    // SPI clock
	input wire logic ssel_n,  // Select
	input wire logic miso_o,  // MISO value
	input wire logic miso_oe, // MISO enable
	input wire logic attn_n   // Attention
);
	localparam int BIT_CYC = `HSP_BIT_CYC;
	logic [15:0] d2h_run_reg;
	logic [15:0] h2d_run_reg;
	logic        d2h_old_reg;
	logic        h2d_old_reg;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);

	////////////////////////////////////////////////////////////////////////
	// Level run lengths; saturated after reset so idle counts as long
	always_ff @(posedge mclk) begin
		d2h_old_reg <= u_d2h;
		h2d_old_reg <= u_h2d;
		if (srst || u_d2h != d2h_old_reg)
			d2h_run_reg <= srst ? 16'hffff : 16'h0001;
		else if (d2h_run_reg != 16'hffff)
			d2h_run_reg <= d2h_run_reg + 16'h0001;
		if (srst || u_h2d != h2d_old_reg)
			h2d_run_reg <= srst ? 16'hffff : 16'h0001;
		else if (h2d_run_reg != 16'hffff)
			h2d_run_reg <= h2d_run_reg + 16'h0001;
	end

	////////////////////////////////////////////////////////////////////////
	sequence s_clk_high;
		sclk [*8];
	endsequence
	sequence s_miso_still;
		$stable(miso_o) [*8];
	endsequence

	AST_MISO_REL: assert property (ssel_n [*6] |-> !miso_oe)
		else $error("MISO driven while deselected");
	AST_MISO_DRV: assert property (!ssel_n [*6] |-> miso_oe)
		else $error("MISO not driven while selected");
	AST_SCLK_IDLE: assert property (ssel_n |-> !sclk)
		else $error("serial clock high while deselected");
	AST_SEL_FIRST: assert property ($rose(sclk) |-> !$past(ssel_n, 8))
		else $error("clock edge too soon after select");
	AST_SCLK_HI: assert property ($rose(sclk) |=> s_clk_high)
		else $error("serial clock high phase too short");
	AST_MISO_HOLD: assert property ($rose(sclk) |-> s_miso_still)
		else $error("MISO moved during high phase");
	AST_ATTN_END: assert property ($rose(attn_n) |-> sclk && !ssel_n)
		else $error("attention released outside a clock edge");
	AST_D2H_BITS: assert property ($rose(u_d2h) |->
		d2h_run_reg % BIT_CYC == 0 && d2h_run_reg <= 9 * BIT_CYC)
		else $error("device UART low run not whole bits");
	AST_D2H_STOP: assert property ($fell(u_d2h) |-> d2h_run_reg >= BIT_CYC)
		else $error("device UART start without stop time");
	AST_H2D_BITS: assert property ($rose(u_h2d) |->
		h2d_run_reg % BIT_CYC == 0 && h2d_run_reg <= 9 * BIT_CYC)
		else $error("host UART low run not whole bits");
endmodule : hsp_link_assertions
`default_nettype wire

// file: tb/host_serial_port_uart_spi_slave_bench.sv
// Self-checking bench joining device and host ends
`timescale 1ns/1ps
`default_nettype none
`include "hsp_defs.svh"
module host_serial_port_uart_spi_slave_bench;
	logic        mclk, srst, psel, penable, pwrite, err, uerr_seen;
	logic        pready, pslverr, irq, pullup_en, utx_valid, utx_ready, urx_valid;
	logic        urx_err, spi_valid, spi_ready, spi_done, attn_seen;
	logic [7:0]  paddr, utx_data, urx_data, spi_wdata, spi_rdata, last_urx, b, q;
	logic [7:0]  mosi_cap, miso_cap;
	logic [31:0] pwdata, prdata, rd, seed;
	int          fail_count, samples_checked, cycles, i;

	hsp_if link_if ();
	hsp_dev hsp_dev_inst (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .pullup_en(pullup_en), .link(link_if.dev));
	hsp_host hsp_host_inst (.mclk(mclk), .srst(srst), .utx_data(utx_data),
		.utx_valid(utx_valid), .utx_ready(utx_ready), .urx_data(urx_data),
		.urx_valid(urx_valid), .urx_err(urx_err), .spi_wdata(spi_wdata),
		.spi_valid(spi_valid), .spi_ready(spi_ready), .spi_rdata(spi_rdata),
		.spi_done(spi_done), .attn_seen(attn_seen), .link(link_if.host));
	hsp_link_assertions hsp_link_assertions_inst (.mclk(mclk), .srst(srst),
		.u_d2h(link_if.u_d2h), .u_h2d(link_if.u_h2d), .sclk(link_if.sclk),
		.ssel_n(link_if.ssel_n), .miso_o(link_if.miso_o), .miso_oe(link_if.miso_oe),
		.attn_n(link_if.attn_n));

	////////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// Run is about 20k cycles; double that before calling it a hang
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			fail_count++;
			summarize();
		end
		if (urx_valid === 1'b1)
			last_urx <= urx_data;
		if (urx_err === 1'b1)
			uerr_seen <= 1'b1;
	end

	// Wire view of both data lines at the master's sampling edge
	always @(posedge link_if.sclk) begin
		mosi_cap <= {mosi_cap[6:0], link_if.mosi};
		miso_cap <= {miso_cap[6:0], link_if.miso};
	end

	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] spi_exp(input logic queued, input logic [7:0] d);
		return {24'h0, queued ? d : `HSP_IDLE_BYTE};
	endfunction : spi_exp

	function automatic logic [31:0] sts_exp(input logic queued);
		return {28'h0, queued, 3'b100};
	endfunction : sts_exp

	task automatic chk_w(input string name, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", name, e, g);
		end
	endtask : chk_w

	task automatic chk_b(input string name, input logic e, input logic g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("FAIL %s expected %b seen %b", name, e, g);
		end
	endtask : chk_b

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk_w($sformatf("register %h", a), e, rd);
	endtask : rchk

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize

	////////////////////////////////////////////////////////////////////////
	initial begin
		{srst, uerr_seen} = 2'b10;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{utx_data, utx_valid, spi_wdata, spi_valid} = '0;
		seed = $urandom(35445);
		repeat (8) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		chk_b("uart idle", 1'b1, link_if.u_d2h);
		chk_b("miso enable", 1'b0, link_if.miso_oe);
		chk_b("attention", 1'b1, link_if.attn_n);
		chk_b("pullup", 1'b1, pullup_en);
		rchk(`HSP_A_CTRL, 32'h1);
		rchk(`HSP_A_MASK, 32'h0);
		apb(1'b0, 8'h22, 32'h0);
		chk_b("unmapped error", 1'b1, err);
		apb(1'b1, `HSP_A_CTRL, 32'h0);
		rchk(`HSP_A_CTRL, 32'h0);
		chk_b("pullup off", 1'b0, pullup_en);
		// Both UART directions at once, known pattern first
		for (i = 0; i < 2; i++) begin
			b = (i == 0) ? 8'h1f : 8'($urandom());
			q = (i == 0) ? 8'h80 : 8'($urandom());
			apb(1'b1, `HSP_A_UTX, {24'h0, b});
			rchk(`HSP_A_UTX, 32'h1);
			utx_data  <= q;
			utx_valid <= 1'b1;
			@(posedge mclk);
			utx_valid <= 1'b0;
			do @(posedge mclk); while (utx_ready !== 1'b1);
			chk_w("host uart byte", {24'h0, b}, {24'h0, last_urx});
			rchk(`HSP_A_URX, {24'h0, q});
			rchk(`HSP_A_STATUS, 32'h1);
			rchk(`HSP_A_STATUS, 32'h0);
		end
		chk_b("uart stop error", 1'b0, uerr_seen);
		apb(1'b1, `HSP_A_MASK, 32'h4);
		// Queued, boundary and idle-fill transfers back to back
		for (i = 0; i < 4; i++) begin
			// delimiter and escape bytes pass raw
			b = (i == 0) ? 8'h80 : (i == 3) ? 8'h7e : 8'($urandom());
			q = (i == 1) ? 8'h01 : (i == 3) ? 8'h7d : 8'($urandom());
			if (i != 2) begin
				apb(1'b1, `HSP_A_STX, {24'h0, q});
				repeat (3) @(posedge mclk);
				chk_b("attention queued", 1'b0, link_if.attn_n);
				chk_b("attention seen", 1'b1, attn_seen);
				// Second byte refused while one waits
				apb(1'b1, `HSP_A_STX, {24'h0, ~q});
				rchk(`HSP_A_STX, 32'h1);
				rchk(`HSP_A_LINK, 32'h2);
			end
			spi_wdata <= b;
			spi_valid <= 1'b1;
			@(posedge mclk);
			spi_valid <= 1'b0;
			do @(posedge mclk); while (spi_done !== 1'b1);
			chk_w("host spi byte", spi_exp(i != 2, q), {24'h0, spi_rdata});
			chk_w("miso wire", spi_exp(i != 2, q), {24'h0, miso_cap});
			chk_w("mosi wire", {24'h0, b}, {24'h0, mosi_cap});
			chk_b("attention done", 1'b1, link_if.attn_n);
			chk_b("select released", 1'b1, link_if.ssel_n);
			chk_b("spi ready", 1'b1, spi_ready);
			chk_b("irq raised", 1'b1, irq);
			rchk(`HSP_A_SRX, {24'h0, b});
			rchk(`HSP_A_STATUS, sts_exp(i != 2));
			@(posedge mclk);
			chk_b("irq cleared", 1'b0, irq);
		end
		summarize();
	end
endmodule : host_serial_port_uart_spi_slave_bench
`default_nettype wire
